// ### odec_defs.svh
// Constants for the operand field decoder
`ifndef ODEC_DEFS_SVH
`define ODEC_DEFS_SVH

`define ODEC_ADD_OPC      8'h04
`define ODEC_ESC_NIBBLE   4'he
`define ODEC_PAGE_ZERO    4'h0
`define ODEC_BIT_POL      7
`define ODEC_BIT_SEL_HI   6
`define ODEC_BIT_SEL_LO   4
`define ODEC_ADDR_W       12
`define ODEC_PC_W         16

`endif

// ### odec_fetch_model.sv
// Instruction fetch model that hands program bytes to the decoder
`timescale 1ns/1ns
module odec_fetch_model (
    input  wire logic           ref_clk,
    output logic                fetch_valid,
    output logic [7:0]          fetch_byte,
    output odec_pkg::odec_fmt_e fetch_format,
    output logic [15:0]         fetch_pc,
    input  wire logic           fetch_ready
);
    initial begin
        fetch_valid  = 1'b0;
        fetch_byte   = 8'h00;
        fetch_format = odec_pkg::ODEC_FMT_NONE;
        fetch_pc     = 16'h0000;
    end
    // ==========================================================
    // Byte sender
    // Opcode first, then operands in object-code order (source before destination, except the immediate format, where destination comes first)
    task automatic send(input odec_pkg::odec_fmt_e fmt, input logic [15:0] pc, input int n,
                        input logic [7:0] b [4], input int gap);
        logic rdy;
        repeat (gap + 1) @(posedge ref_clk);
        for (int i = 0; i <= n; i++) begin
            fetch_valid  <= 1'b1;
            fetch_byte   <= b[i];
            // Format and address only count with the opcode, so they are scrambled afterwards
            fetch_format <= (i == 0) ? fmt : odec_pkg::odec_fmt_e'(4'hf ^ fmt);
            fetch_pc     <= (i == 0) ? pc : ~pc;
            do begin
                @(negedge ref_clk);
                rdy = fetch_ready;
                @(posedge ref_clk);
            end while (rdy !== 1'b1);
        end
        // Released byte lane shows the inverse so a stale byte cannot pass for a good one
        fetch_valid <= 1'b0;
        fetch_byte  <= ~b[n];
    endtask
endmodule

// ### odec_pkg.sv
// Types shared by the operand field decoder files
package odec_pkg;

    typedef enum logic [3:0] {
        ODEC_FMT_NONE,
        ODEC_FMT_ADD_RR,
        ODEC_FMT_R_R,
        ODEC_FMT_ER_ER,
        ODEC_FMT_PAIR,
        ODEC_FMT_DIRECT,
        ODEC_FMT_RA,
        ODEC_FMT_X,
        ODEC_FMT_BIT,
        ODEC_FMT_IMMED,
        ODEC_FMT_VEC
    } odec_fmt_e;

    typedef enum logic [2:0] {
        ODEC_S_OPC,
        ODEC_S_OPND,
        ODEC_S_RD1,
        ODEC_S_RD2,
        ODEC_S_EXEC,
        ODEC_S_DONE
    } odec_state_e;

endpackage

// ### odec_regfile.sv
// Register file memory with registered read data
`timescale 1ns/1ns
module odec_regfile #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data comes out of a register; a same-cycle write returns old data
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ### odec_top.sv
// Operand field decoder with register-to-register add write-back
`timescale 1ns/1ns
`include "odec_defs.svh"
module odec_top #(
    parameter int AW = `ODEC_ADDR_W
) (
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    input  wire logic                    fetch_valid,
    input  wire logic [7:0]              fetch_byte,
    input  wire odec_pkg::odec_fmt_e     fetch_format,
    input  wire logic [`ODEC_PC_W-1:0]   fetch_pc,
    output logic                         fetch_ready,
    input  wire logic [7:0]              reg_ptr,
    input  wire logic                    load_en,
    input  wire logic [AW-1:0]           load_addr,
    input  wire logic [7:0]              load_data,
    output logic                         load_ready,
    output logic                         dec_valid,
    output odec_pkg::odec_fmt_e          dec_format,
    output logic [7:0]                   dec_opcode,
    output logic [AW-1:0]                src_addr,
    output logic [AW-1:0]                dst_addr,
    output logic [2:0]                   bit_sel,
    output logic                         polarity,
    output logic [`ODEC_PC_W-1:0]        direct_target_word,
    output logic [7:0]                   immediate_byte,
    output logic [7:0]                   trap_vector,
    output logic [`ODEC_PC_W-1:0]        rel_target,
    output logic [AW-1:0]                index_addr,
    output logic                         pair_fault,
    output logic [7:0]                   wb_data
);
    // ==========================================================
    // Parameter check
    if (AW != `ODEC_ADDR_W) begin : g_bad_aw
        $error("odec_top: AW must equal the 12-bit extended register width");
    end

    // ==========================================================
    // State
    odec_pkg::odec_state_e        state, next_state;
    odec_pkg::odec_fmt_e          fmt, next_fmt, next_dec_format;
    logic [7:0]                   opc, next_opc, rp_cap, next_rp_cap, b1, next_b1, b2, next_b2, b3, next_b3;
    logic [`ODEC_PC_W-1:0]        pc, next_pc, next_direct_target_word, next_rel_target;
    logic [1:0]                   cnt, next_cnt;
    logic [7:0]                   val_a, next_val_a, next_dec_opcode, next_immediate_byte, next_trap_vector;
    logic [7:0]                   next_wb_data, rf_wr_data, rf_rd_data, add_sum;
    logic                         next_dec_valid, next_polarity, next_pair_fault, rf_wr_en;
    logic [AW-1:0]                next_src_addr, next_dst_addr, next_index_addr, rf_wr_addr, rf_rd_addr;
    logic [2:0]                   next_bit_sel;

    // ==========================================================
    // Helpers
    function automatic logic [1:0] opnd_count(input odec_pkg::odec_fmt_e f);
        unique case (f)
            odec_pkg::ODEC_FMT_NONE:   opnd_count = 2'd0;
            odec_pkg::ODEC_FMT_ER_ER:  opnd_count = 2'd3;
            odec_pkg::ODEC_FMT_ADD_RR,
            odec_pkg::ODEC_FMT_R_R,
            odec_pkg::ODEC_FMT_DIRECT,
            odec_pkg::ODEC_FMT_X,
            odec_pkg::ODEC_FMT_IMMED:  opnd_count = 2'd2;
            default:                   opnd_count = 2'd1;
        endcase
    endfunction

    // Escaped byte picks a working register in the group the pointer selects
    function automatic logic [AW-1:0] reg8_addr(input logic [7:0] b, input logic [7:0] rp);
        if (b[7:4] == `ODEC_ESC_NIBBLE) begin
            reg8_addr = {rp[3:0], rp[7:4], b[3:0]};
        end else begin
            reg8_addr = {`ODEC_PAGE_ZERO, b};
        end
    endfunction

    function automatic logic [AW-1:0] work_addr(input logic [3:0] n, input logic [7:0] rp);
        work_addr = {rp[3:0], rp[7:4], n};
    endfunction

    // ==========================================================
    // Register file
    odec_regfile #(
        .AW (AW),
        .DW (8)
    ) u_regfile (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .wr_en   (rf_wr_en),
        .wr_addr (rf_wr_addr),
        .wr_data (rf_wr_data),
        .rd_addr (rf_rd_addr),
        .rd_data (rf_rd_data)
    );

    assign add_sum = val_a + rf_rd_data;

    // Write-back owns the port in the execute cycle; loads wait out that cycle
    always_comb begin
        load_ready = (state != odec_pkg::ODEC_S_EXEC);
        rf_wr_en   = load_en && load_ready;
        rf_wr_addr = load_addr;
        rf_wr_data = load_data;
        if (state == odec_pkg::ODEC_S_EXEC) begin
            rf_wr_en   = 1'b1;
            rf_wr_addr = reg8_addr(b2, rp_cap);
            rf_wr_data = add_sum;
        end
        if (state == odec_pkg::ODEC_S_RD1) begin
            rf_rd_addr = reg8_addr(b1, rp_cap);
        end else begin
            rf_rd_addr = reg8_addr(b2, rp_cap);
        end
    end

    assign fetch_ready = (state == odec_pkg::ODEC_S_OPC) || (state == odec_pkg::ODEC_S_OPND);

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_state      = state;
        next_fmt        = fmt;
        next_dec_format = dec_format;
        next_dec_valid  = 1'b0;
        {next_opc, next_pc, next_rp_cap, next_b1, next_b2, next_b3, next_cnt, next_val_a}
            = {opc, pc, rp_cap, b1, b2, b3, cnt, val_a};
        // Fields a format does not use keep their last decoded value; pair_fault clears on every decode but a pair decode
        {next_dec_opcode, next_src_addr, next_dst_addr, next_bit_sel, next_polarity, next_direct_target_word,
         next_immediate_byte, next_trap_vector, next_rel_target, next_index_addr, next_pair_fault, next_wb_data}
            = {dec_opcode, src_addr, dst_addr, bit_sel, polarity, direct_target_word,
               immediate_byte, trap_vector, rel_target, index_addr, pair_fault, wb_data};
        unique case (state)
            odec_pkg::ODEC_S_OPC: begin
                if (fetch_valid) begin
                    next_opc    = fetch_byte;
                    next_fmt    = fetch_format;
                    next_pc     = fetch_pc;
                    next_rp_cap = reg_ptr;
                    next_cnt    = 2'd0;
                    next_state  = (opnd_count(fetch_format) == 2'd0) ? odec_pkg::ODEC_S_DONE
                                                                     : odec_pkg::ODEC_S_OPND;
                end
            end
            odec_pkg::ODEC_S_OPND: begin
                if (fetch_valid) begin
                    unique case (cnt)
                        2'd0:    next_b1 = fetch_byte;
                        2'd1:    next_b2 = fetch_byte;
                        default: next_b3 = fetch_byte;
                    endcase
                    next_cnt = cnt + 2'd1;
                    if (cnt + 2'd1 == opnd_count(fmt)) begin
                        if (fmt == odec_pkg::ODEC_FMT_ADD_RR || fmt == odec_pkg::ODEC_FMT_X) begin
                            next_state = odec_pkg::ODEC_S_RD1;
                        end else begin
                            next_state = odec_pkg::ODEC_S_DONE;
                        end
                    end
                end
            end
            odec_pkg::ODEC_S_RD1: begin
                next_state = odec_pkg::ODEC_S_RD2;
            end
            odec_pkg::ODEC_S_RD2: begin
                next_val_a = rf_rd_data;
                next_state = (fmt == odec_pkg::ODEC_FMT_ADD_RR) ? odec_pkg::ODEC_S_EXEC
                                                                : odec_pkg::ODEC_S_DONE;
            end
            odec_pkg::ODEC_S_EXEC: begin
                next_wb_data = add_sum;
                next_state   = odec_pkg::ODEC_S_DONE;
            end
            odec_pkg::ODEC_S_DONE: begin
                next_dec_valid  = 1'b1;
                next_dec_format = fmt;
                next_dec_opcode = opc;
                next_pair_fault = 1'b0;
                next_state      = odec_pkg::ODEC_S_OPC;
                unique case (fmt)
                    odec_pkg::ODEC_FMT_NONE: begin
                    end
                    odec_pkg::ODEC_FMT_ADD_RR,
                    odec_pkg::ODEC_FMT_R_R: begin
                        next_src_addr = reg8_addr(b1, rp_cap);
                        next_dst_addr = reg8_addr(b2, rp_cap);
                    end
                    odec_pkg::ODEC_FMT_ER_ER: begin
                        next_src_addr = {b1, b2[7:4]};
                        next_dst_addr = {b2[3:0], b3};
                    end
                    odec_pkg::ODEC_FMT_PAIR: begin
                        next_dst_addr   = reg8_addr(b1, rp_cap);
                        next_pair_fault = b1[0];
                    end
                    odec_pkg::ODEC_FMT_DIRECT: begin
                        next_direct_target_word = {b1, b2};
                    end
                    odec_pkg::ODEC_FMT_RA: begin
                        // Next instruction starts two bytes past the opcode
                        next_rel_target = pc + `ODEC_PC_W'(2) + {{8{b1[7]}}, b1};
                    end
                    odec_pkg::ODEC_FMT_X: begin
                        next_src_addr   = reg8_addr(b1, rp_cap);
                        next_index_addr = AW'({4'h0, val_a} + {{4{b2[7]}}, b2});
                    end
                    odec_pkg::ODEC_FMT_BIT: begin
                        next_polarity = b1[`ODEC_BIT_POL];
                        next_bit_sel  = b1[`ODEC_BIT_SEL_HI:`ODEC_BIT_SEL_LO];
                        next_dst_addr = work_addr(b1[3:0], rp_cap);
                    end
                    odec_pkg::ODEC_FMT_IMMED: begin
                        // Destination precedes data in this layout
                        next_dst_addr       = reg8_addr(b1, rp_cap);
                        next_immediate_byte = b2;
                    end
                    odec_pkg::ODEC_FMT_VEC: begin
                        next_trap_vector = b1;
                    end
                    default: begin
                    end
                endcase
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state      <= odec_pkg::ODEC_S_OPC;
            fmt        <= odec_pkg::ODEC_FMT_NONE;
            dec_format <= odec_pkg::ODEC_FMT_NONE;
            {opc, pc, rp_cap, b1, b2, b3, cnt, val_a} <= '0;
            {dec_valid, dec_opcode, src_addr, dst_addr, bit_sel, polarity, direct_target_word,
             immediate_byte, trap_vector, rel_target, index_addr, pair_fault, wb_data} <= '0;
        end else begin
            state      <= next_state;
            fmt        <= next_fmt;
            dec_format <= next_dec_format;
            {opc, pc, rp_cap, b1, b2, b3, cnt, val_a}
                <= {next_opc, next_pc, next_rp_cap, next_b1, next_b2, next_b3, next_cnt, next_val_a};
            {dec_valid, dec_opcode, src_addr, dst_addr, bit_sel, polarity, direct_target_word,
             immediate_byte, trap_vector, rel_target, index_addr, pair_fault, wb_data}
                <= {next_dec_valid, next_dec_opcode, next_src_addr, next_dst_addr, next_bit_sel, next_polarity,
                    next_direct_target_word, next_immediate_byte, next_trap_vector, next_rel_target,
                    next_index_addr, next_pair_fault, next_wb_data};
        end
    end

    // ==========================================================
    // Assertions
    sequence seq_exec_to_done;
        (state == odec_pkg::ODEC_S_EXEC) ##1 (state == odec_pkg::ODEC_S_DONE);
    endsequence

    a_add_writeback: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state == odec_pkg::ODEC_S_RD2 && fmt == odec_pkg::ODEC_FMT_ADD_RR)
        |=> seq_exec_to_done ##1 (dec_valid && wb_data == $past(add_sum, 2)))
        else $error("add result not written back");
    a_order_src_dst: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dec_valid && dec_format == odec_pkg::ODEC_FMT_R_R)
        |-> (src_addr == reg8_addr(b1, rp_cap) && dst_addr == reg8_addr(b2, rp_cap)))
        else $error("source and destination bytes swapped");
    a_escape_map: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dec_valid && dec_format == odec_pkg::ODEC_FMT_R_R && b1[7:4] == 4'he)
        |-> (src_addr == {rp_cap[3:0], rp_cap[7:4], b1[3:0]}))
        else $error("escaped register mapped wrongly");
    a_rel_target: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dec_valid && dec_format == odec_pkg::ODEC_FMT_RA)
        |-> (rel_target == 16'(pc + 16'h0002 + {{8{b1[7]}}, b1})))
        else $error("relative target wrong");
    a_index_sum: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state == odec_pkg::ODEC_S_RD2 && fmt == odec_pkg::ODEC_FMT_X)
        |-> ##2 (dec_valid && index_addr == 12'({4'h0, $past(rf_rd_data, 2)} + {{4{b2[7]}}, b2})))
        else $error("index address wrong");
    a_pair_even: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dec_valid && dec_format == odec_pkg::ODEC_FMT_PAIR) |-> (pair_fault == dst_addr[0]))
        else $error("odd pair not flagged");
    a_ext_fields: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dec_valid && dec_format == odec_pkg::ODEC_FMT_ER_ER) |-> ({src_addr, dst_addr} == {b1, b2, b3}))
        else $error("extended address wrong");
    a_direct_word: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dec_valid && dec_format == odec_pkg::ODEC_FMT_DIRECT) |-> (direct_target_word == {b1, b2}))
        else $error("direct target wrong");
    a_bit_fields: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dec_valid && dec_format == odec_pkg::ODEC_FMT_BIT) |-> ({polarity, bit_sel} == b1[7:4]))
        else $error("bit or polarity field wrong");
    a_byte_fields: assert property (@(posedge ref_clk) disable iff (!nrst)
        (dec_valid && dec_format == odec_pkg::ODEC_FMT_VEC) |-> (trap_vector == b1) ##1 !dec_valid)
        else $error("trap vector wrong");
endmodule

// ### operand_field_decode_tb_top.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/1ns
module operand_field_decode_tb_top;
    logic                ref_clk, nrst, fetch_valid, fetch_ready, load_en, load_ready;
    logic                dec_valid, polarity, pair_fault;
    logic [7:0]          fetch_byte, reg_ptr, load_data, dec_opcode, immediate_byte, trap_vector, wb_data;
    logic [7:0]          rp_v, a, c;
    logic [11:0]         load_addr, src_addr, dst_addr, index_addr, e12;
    logic [15:0]         fetch_pc, direct_target_word, rel_target, pc_v;
    logic [2:0]          bit_sel;
    odec_pkg::odec_fmt_e fetch_format, dec_format;
    logic [31:0]         seed;
    logic [7:0]          bs [4];
    int                  errors, n_tests, cycles;

    odec_top i_odec_top (.ref_clk, .nrst, .fetch_valid, .fetch_byte, .fetch_format, .fetch_pc,
        .fetch_ready, .reg_ptr, .load_en, .load_addr, .load_data, .load_ready, .dec_valid,
        .dec_format, .dec_opcode, .src_addr, .dst_addr, .bit_sel, .polarity, .direct_target_word,
        .immediate_byte, .trap_vector, .rel_target, .index_addr, .pair_fault, .wb_data);
    odec_fetch_model i_odec_fetch_model (.ref_clk, .fetch_valid, .fetch_byte, .fetch_format,
        .fetch_pc, .fetch_ready);

    always #10 ref_clk = ~ref_clk;

    // ==========================================================
    // Helpers
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    // Escaped byte falls in the working-register window of the pointer
    function automatic logic [11:0] regmap(input logic [7:0] rp, input logic [7:0] b);
        return (b[7:4] == 4'he) ? {rp[3:0], rp[7:4], b[3:0]} : {4'h0, b};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("Checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic preload(input logic [11:0] ad, input logic [7:0] d);
        logic rdy;
        @(posedge ref_clk);
        load_en   <= 1'b1;
        load_addr <= ad;
        load_data <= d;
        do begin
            @(negedge ref_clk);
            rdy = load_ready;
            @(posedge ref_clk);
        end while (rdy !== 1'b1);
        load_en <= 1'b0;
    endtask
    // Sends one instruction and waits a bounded time for its decode pulse
    task automatic run(input odec_pkg::odec_fmt_e fmt, input int n);
        int w;
        @(posedge ref_clk);
        reg_ptr <= rp_v;
        i_odec_fetch_model.send(fmt, pc_v, n, bs, rnd() % 3);
        w = 0;
        do begin
            @(negedge ref_clk);
            w++;
        end while (dec_valid !== 1'b1 && w < 20);
        chk(dec_valid, 1'b1);
        chk(dec_format, fmt);
        chk(dec_opcode, bs[0]);
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        ref_clk = 1'b0; nrst = 1'b0; load_en = 1'b0; load_addr = 12'h000; load_data = 8'h00;
        reg_ptr = 8'h00; errors = 0; n_tests = 0; cycles = 0; seed = 32'd69; pc_v = 16'h0000;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        chk(dec_valid, 1'b0);
        chk(load_ready, 1'b1);
        chk(fetch_ready, 1'b1);
        // Add with escaped source: result lands in destination and feeds the next add
        rp_v = rnd(); a = rnd(); c = rnd();
        preload(regmap(rp_v, 8'he8), a);
        preload(12'h043, c);
        bs = '{8'h04, 8'he8, 8'h43, 8'h00};
        run(odec_pkg::ODEC_FMT_ADD_RR, 2);
        chk(src_addr, regmap(rp_v, 8'he8));
        chk(dst_addr, 12'h043);
        chk(wb_data, 8'(a + c));
        run(odec_pkg::ODEC_FMT_ADD_RR, 2);
        chk(wb_data, 8'(a + a + c));
        for (int i = 0; i < 8; i++) begin
            rp_v = rnd();
            bs = '{rnd(), rnd(), rnd(), 8'h00};
            bs[1][7:4] = i[0] ? 4'he : bs[1][7:4];
            bs[2][7:4] = i[1] ? 4'he : bs[2][7:4];
            run(odec_pkg::ODEC_FMT_R_R, 2);
            chk(src_addr, regmap(rp_v, bs[1]));
            chk(dst_addr, regmap(rp_v, bs[2]));
        end
        // Wide fields at both ends of their range
        for (int i = 0; i < 4; i++) begin
            bs = '{rnd(), rnd(), rnd(), rnd()};
            if (i < 2) begin
                bs = '{4{(i == 0) ? 8'hff : 8'h00}};
            end
            run(odec_pkg::ODEC_FMT_ER_ER, 3);
            chk(src_addr, {bs[1], bs[2][7:4]});
            chk(dst_addr, {bs[2][3:0], bs[3]});
            run(odec_pkg::ODEC_FMT_DIRECT, 2);
            chk(direct_target_word, {bs[1], bs[2]});
            run(odec_pkg::ODEC_FMT_IMMED, 2);
            chk(immediate_byte, bs[2]);
            run(odec_pkg::ODEC_FMT_VEC, 1);
            chk(trap_vector, bs[1]);
        end
        // Signed offsets at +127 and -128, with a wrapping program address
        for (int i = 0; i < 4; i++) begin
            pc_v = (i == 1) ? 16'hffff : {rnd(), rnd()};
            rp_v = rnd(); c = rnd();
            bs = '{rnd(), (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : rnd(), 8'h00, 8'h00};
            run(odec_pkg::ODEC_FMT_RA, 1);
            chk(rel_target, pc_v + 16'h0002 + {{8{bs[1][7]}}, bs[1]});
            preload(regmap(rp_v, bs[1]), c);
            bs[2] = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : rnd();
            e12 = {4'h0, c} + {{4{bs[2][7]}}, bs[2]};
            run(odec_pkg::ODEC_FMT_X, 2);
            chk(index_addr, e12);
        end
        // Every bit position under both polarities
        for (int i = 0; i < 16; i++) begin
            rp_v = rnd();
            bs = '{rnd(), rnd(), 8'h00, 8'h00};
            bs[1][7:4] = {i[0], i[3:1]};
            run(odec_pkg::ODEC_FMT_BIT, 1);
            chk(polarity, i[0]);
            chk(bit_sel, i[3:1]);
            chk(dst_addr, {rp_v[3:0], rp_v[7:4], bs[1][3:0]});
        end
        // Odd pair faults, the following even one clears it
        for (int i = 0; i < 4; i++) begin
            rp_v = rnd();
            bs = '{rnd(), (i == 0) ? 8'hff : (i == 1) ? 8'hfe : rnd(), 8'h00, 8'h00};
            run(odec_pkg::ODEC_FMT_PAIR, 1);
            chk(pair_fault, bs[1][0]);
            chk(dst_addr, regmap(rp_v, bs[1]));
        end
        results();
    end
endmodule
